// ---- verilog/timer2_consts.vh ----
// constants for the reload/split/capture timer
`ifndef TIMER2_CONSTS_VH
`define TIMER2_CONSTS_VH
// register addresses
`define ADDR_CTRL 8'hC8
`define ADDR_RELOAD_LO 8'hCA
`define ADDR_RELOAD_HI 8'hCB
`define ADDR_COUNT_LO 8'hCC
`define ADDR_COUNT_HI 8'hCD
`define ADDR_CLKCTRL 8'h8E
// control register fields
`define CTL_HIGH_FLAG 7
`define CTL_LOW_FLAG 6
`define CTL_LOW_IRQ_EN 5
`define CTL_CAPTURE_EN 4
`define CTL_SPLIT 3
`define CTL_RUN 2
`define CTL_CAP_SRC 1
`define CTL_EXT_SEL 0
// clock control fields used here
`define CKC_HIGH_SEL 5
`define CKC_LOW_SEL 4
// reset value and all-ones byte
`define RST_BYTE 8'h00
`define BYTE_ALL_ONES 8'hFF
// prescalers
`define DIV12_LAST 4'hB
`define DIV12_ZERO 4'h0
`define DIV12_ONE 4'h1
`define DIV8_LAST 3'h7
`define DIV8_ZERO 3'h0
`define DIV8_ONE 3'h1
`endif

// ---- verilog/div8_sync.v ----
// synchronise an outside oscillator and emit one pulse per eight of its cycles
`timescale 1ns/1ps
`include "timer2_consts.vh"
module div8_sync (
    input wire clk,
    input wire resetn,
    input wire osc_in,
    output reg tick_q
);
    reg meta_q;
    reg sync_q;
    reg prev_q;
    reg [2:0] cnt_q;
    wire rise;

    // three flops; the edge detector looks at the second and third, never the first
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= osc_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;

    // count rising edges; pulse once per eighth edge
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= `DIV8_ZERO;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= rise && (cnt_q == `DIV8_LAST);
            if (rise)
                cnt_q <= cnt_q + `DIV8_ONE;
        end
    end
endmodule // div8_sync

// ---- verilog/timer2_core.v ----
// reload/split/capture timer with its byte-wide special function registers
`timescale 1ns/1ps
`include "timer2_consts.vh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - 16-bit mode wraps, reloads, sets high flag
// - interrupt on every 16-bit overflow when enabled
// - low-byte wrap also interrupts if low enable
// - split mode: two independent reloading 8-bit timers
// - run gates whole timer, or high byte only
// - per-byte clock select: system, /12, ext/8 or rtc/8
// - divided outside clock synchronised before use
// - high flag set on high byte wrap
// - low flag set on low wrap, any mode
// - split mode interrupts from high, optionally low
// - flags only cleared by software writes
// - capture copies count to reload, sets high flag
// - capture source: 0 rtc/8, 1 ext/8
// - with ext select, source bit picks count clock
// - ext select picks /12 or divided source
// - low select clocks whole timer or low byte
// - high select matters only in split mode
module timer2_core (
    input wire CLK,
    input wire RESETN,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_WE,
    input wire SFR_RE,
    output reg [7:0] SFR_RDATA,
    input wire [7:0] CLOCK_CONTROL,
    input wire TIMER_IRQ_ENABLE,
    input wire EXT_OSC,
    input wire RTC_OSC,
    output reg IRQ
);
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg [7:0] rld_lo_q;
    reg [7:0] rld_lo_d;
    reg [7:0] rld_hi_q;
    reg [7:0] rld_hi_d;
    reg [7:0] cnt_lo_q;
    reg [7:0] cnt_lo_d;
    reg [7:0] cnt_hi_q;
    reg [7:0] cnt_hi_d;
    reg [3:0] div12_q;
    reg div12_tick_q;
    wire ext_tick;
    wire rtc_tick;
    wire split;
    wire run;
    wire div_tick;
    wire cap_tick;
    wire lo_tick;
    wire hi_tick;
    wire lo_en;
    wire hi_en;
    wire lo_wrap;
    wire hi_wrap;
    wire wr_cnt_lo;
    wire wr_cnt_hi;
    wire [7:0] rdata_d;
    wire irq_d;

    //////////////////////////////////////////////////////////////////////////
    // outside oscillators, synchronised and divided by eight
    div8_sync u_ext_div (
        .clk(CLK),
        .resetn(RESETN),
        .osc_in(EXT_OSC),
        .tick_q(ext_tick)
    );
    div8_sync u_rtc_div (
        .clk(CLK),
        .resetn(RESETN),
        .osc_in(RTC_OSC),
        .tick_q(rtc_tick)
    );

    // free-running divide by twelve of the system clock
    // it never restarts, so the first /12 step after run lands anywhere in 12 clocks
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            div12_q <= `DIV12_ZERO;
            div12_tick_q <= 1'b0;
        end
        else
        begin
            div12_tick_q <= (div12_q == `DIV12_LAST);
            div12_q <= (div12_q == `DIV12_LAST) ? `DIV12_ZERO : div12_q + `DIV12_ONE;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // clock selection and enables
    assign split = ctrl_q[`CTL_SPLIT];
    assign run = ctrl_q[`CTL_RUN];
    // non-system source: /12, or the divided clock chosen by the source bit
    assign div_tick = !ctrl_q[`CTL_EXT_SEL] ? div12_tick_q :
                      (ctrl_q[`CTL_CAP_SRC] ? rtc_tick : ext_tick);
    // capture trigger: 0 uses rtc/8, 1 uses ext/8
    assign cap_tick = ctrl_q[`CTL_CAPTURE_EN] &
                      (ctrl_q[`CTL_CAP_SRC] ? ext_tick : rtc_tick);
    assign lo_tick = CLOCK_CONTROL[`CKC_LOW_SEL] ? 1'b1 : div_tick;
    // high select ignored unless split
    assign hi_tick = !split ? lo_tick :
                     (CLOCK_CONTROL[`CKC_HIGH_SEL] ? 1'b1 : div_tick);
    // split low byte runs regardless of run bit
    assign lo_en = lo_tick & (split | run);
    // in 16-bit mode the high byte steps on the low byte's carry
    assign hi_en = split ? (hi_tick & run) : (lo_en & (cnt_lo_q == `BYTE_ALL_ONES));
    assign lo_wrap = lo_en & (cnt_lo_q == `BYTE_ALL_ONES);
    assign hi_wrap = hi_en & (cnt_hi_q == `BYTE_ALL_ONES);

    // a software write to a count byte replaces that byte's step this cycle
    assign wr_cnt_lo = SFR_WE & (SFR_ADDR == `ADDR_COUNT_LO);
    assign wr_cnt_hi = SFR_WE & (SFR_ADDR == `ADDR_COUNT_HI);

    //////////////////////////////////////////////////////////////////////////
    // next state of registers; reloads, captures and flag sets override software writes
    always @*
    begin
        ctrl_d = ctrl_q;
        rld_lo_d = rld_lo_q;
        rld_hi_d = rld_hi_q;
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        // software writes first, so later hardware terms win
        // an unmapped address leaves every register as it was
        if (SFR_WE)
        begin
            case (SFR_ADDR)
                `ADDR_CTRL: ctrl_d = SFR_WDATA;
                `ADDR_RELOAD_LO: rld_lo_d = SFR_WDATA;
                `ADDR_RELOAD_HI: rld_hi_d = SFR_WDATA;
                `ADDR_COUNT_LO: cnt_lo_d = SFR_WDATA;
                `ADDR_COUNT_HI: cnt_hi_d = SFR_WDATA;
                default: ctrl_d = ctrl_q;
            endcase
        end

        // counting; a byte written this cycle keeps the written value
        if (lo_en & ~wr_cnt_lo)
            cnt_lo_d = cnt_lo_q + 8'h01;
        if (hi_en & ~wr_cnt_hi)
            cnt_hi_d = cnt_hi_q + 8'h01;

        // wrap reloads beat a same-cycle software write
        if (split)
        begin
            if (lo_wrap)
                cnt_lo_d = rld_lo_q;
            if (hi_wrap)
                cnt_hi_d = rld_hi_q;
        end
        else if (hi_wrap)
        begin
            cnt_lo_d = rld_lo_q;
            cnt_hi_d = rld_hi_q;
        end

        // capture takes the count as it stands this cycle
        // capture is not blocked in split mode; software keeps 16-bit mode
        if (cap_tick)
        begin
            rld_lo_d = cnt_lo_q;
            rld_hi_d = cnt_hi_q;
        end

        // flag sets win over a same-cycle software clear
        if (lo_wrap)
            ctrl_d[`CTL_LOW_FLAG] = 1'b1;
        if (hi_wrap | cap_tick)
            ctrl_d[`CTL_HIGH_FLAG] = 1'b1;
    end

    // interrupt level; a stuck flag keeps requesting until software clears it
    assign irq_d = TIMER_IRQ_ENABLE & (ctrl_d[`CTL_HIGH_FLAG] |
                   (ctrl_d[`CTL_LOW_FLAG] & ctrl_d[`CTL_LOW_IRQ_EN]));

    // read mux; unmapped addresses read zero
    assign rdata_d = (SFR_ADDR == `ADDR_CTRL) ? ctrl_q :
                     (SFR_ADDR == `ADDR_RELOAD_LO) ? rld_lo_q :
                     (SFR_ADDR == `ADDR_RELOAD_HI) ? rld_hi_q :
                     (SFR_ADDR == `ADDR_COUNT_LO) ? cnt_lo_q :
                     (SFR_ADDR == `ADDR_COUNT_HI) ? cnt_hi_q : `RST_BYTE;

    //////////////////////////////////////////////////////////////////////////
    // state registers
    // read data moves only on a read strobe and holds between reads
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctrl_q <= `RST_BYTE;
            rld_lo_q <= `RST_BYTE;
            rld_hi_q <= `RST_BYTE;
            cnt_lo_q <= `RST_BYTE;
            cnt_hi_q <= `RST_BYTE;
            SFR_RDATA <= `RST_BYTE;
            IRQ <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rld_lo_q <= rld_lo_d;
            rld_hi_q <= rld_hi_d;
            cnt_lo_q <= cnt_lo_d;
            cnt_hi_q <= cnt_hi_d;
            IRQ <= irq_d;
            if (SFR_RE)
                SFR_RDATA <= rdata_d;
        end
    end
endmodule // timer2_core

// ---- tb/timer2_chk.sv ----
// port checker for the reload/split/capture timer
`timescale 1ns/1ps
module timer2_chk (
    input wire CLK,
    input wire RESETN,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_WE,
    input wire SFR_RE,
    input wire [7:0] SFR_RDATA,
    input wire TIMER_IRQ_ENABLE,
    input wire IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // control reads; flag bits are the only ones hardware may change
    wire rc = SFR_RE && SFR_ADDR == 8'hC8;
    a_irq_en: assert property (IRQ |-> $past(TIMER_IRQ_ENABLE)) else $error("irq no enable");
    a_irq_fall: assert property ($fell(IRQ) |-> $past(SFR_WE) || !$past(TIMER_IRQ_ENABLE)) else $error("irq fell");
    a_irq_src: assert property (rc && $past(TIMER_IRQ_ENABLE) |=>
        $past(IRQ) == (SFR_RDATA[7] || SFR_RDATA[6] && SFR_RDATA[5])) else $error("irq vs flags");
    a_unmapped_zero: assert property (SFR_RE && SFR_ADDR == 8'hC9 |=> SFR_RDATA == 8'h00) else $error("unmapped");
    a_rdata_hold: assert property (!SFR_RE |=> $stable(SFR_RDATA)) else $error("rdata moved");
    a_ctrl_readback: assert property (SFR_WE && SFR_ADDR == 8'hC8 ##1 rc && !SFR_WE |=>
        (SFR_RDATA & 8'h3F) == ($past(SFR_WDATA, 2) & 8'h3F)) else $error("ctrl readback");
    a_flag_sticky: assert property (rc && !SFR_WE ##1 rc |=>
        ($past(SFR_RDATA) & ~SFR_RDATA & 8'hC0) == 8'h00) else $error("flag self-cleared");
    a_reset_clear: assert property (!$past(RESETN) |-> SFR_RDATA == 8'h00 && !IRQ) else $error("reset state");
    c_irq: cover property ($rose(IRQ));
    c_flag: cover property (rc ##1 SFR_RDATA[7]);
    c_low_flag: cover property (rc ##1 SFR_RDATA[6]);
    c_low_irq: cover property (rc ##1 SFR_RDATA[6] && SFR_RDATA[5] && IRQ);
endmodule // timer2_chk
bind timer2_core timer2_chk u_chk (.CLK(CLK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .TIMER_IRQ_ENABLE(TIMER_IRQ_ENABLE), .IRQ(IRQ));

// ---- tb/testbench.sv ----
// self-checking bench for the reload/split/capture timer
`timescale 1ns/1ps
module testbench;
    reg CLK = 1'b0;
    reg RESETN = 1'b0;
    reg [7:0] SFR_ADDR = 8'h00;
    reg [7:0] SFR_WDATA = 8'h00;
    reg SFR_WE = 1'b0;
    reg SFR_RE = 1'b0;
    reg [7:0] CLOCK_CONTROL = 8'h10;
    reg TIMER_IRQ_ENABLE = 1'b0;
    reg EXT_OSC = 1'b0;
    reg RTC_OSC = 1'b0;
    wire [7:0] SFR_RDATA;
    wire IRQ;
    integer err_total = 0;
    integer samples_checked = 0;
    integer i;
    reg [7:0] v;
    reg [7:0] lo;
    reg [7:0] hi;
    timer2_core DUT (.CLK(CLK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE),
        .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .CLOCK_CONTROL(CLOCK_CONTROL),
        .TIMER_IRQ_ENABLE(TIMER_IRQ_ENABLE), .EXT_OSC(EXT_OSC), .RTC_OSC(RTC_OSC), .IRQ(IRQ));
    // clocks; oscillators free-run, unrelated in phase to the system clock
    always #4 CLK = ~CLK;
    always #21 EXT_OSC = ~EXT_OSC;
    always #53 RTC_OSC = ~RTC_OSC;
    ////////////////////////////////////////////////////////////////////////////
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp)
            begin
                err_total = err_total + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // write, then read the same place back so the checker sees it
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge CLK);
            SFR_RE = 1'b0;
            SFR_WE = 1'b1;
            SFR_ADDR = a;
            SFR_WDATA = d;
            @(negedge CLK);
            SFR_WE = 1'b0;
            SFR_RE = 1'b1;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge CLK);
            SFR_RE = 1'b1;
            SFR_ADDR = a;
            @(negedge CLK);
            d = SFR_RDATA;
        end
    endtask
    // count from zero for a fixed span, stop, and bound the low byte
    task run(input [7:0] ckc, input [7:0] ctl, input [7:0] mn, input [7:0] mx);
        begin
            CLOCK_CONTROL = ckc;
            wr(8'hCD, 8'h00);
            wr(8'hCC, 8'h00);
            wr(8'hC8, ctl);
            repeat (240) @(negedge CLK);
            wr(8'hC8, 8'h00);
            rd(8'hCC, v);
            chk({7'h0, v >= mn && v <= mx}, 8'h01);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // reset values, and an unmapped place that must read zero
    task t_reset;
        begin
            wr(8'hC9, 8'hA5);
            for (i = 0; i < 6; i = i + 1)
            begin
                rd(8'hC8 + i[7:0], v);
                chk(v, 8'h00);
            end
            $display("test reset done");
        end
    endtask
    // 16-bit wrap at system clock: reload, both flags, level interrupt
    task t_reload;
        begin
            TIMER_IRQ_ENABLE = 1'b1;
            wr(8'hCB, 8'h12);
            wr(8'hCA, 8'h34);
            wr(8'hCD, 8'hFF);
            wr(8'hCC, 8'hF0);
            wr(8'hC8, 8'h04);
            repeat (30) @(negedge CLK);
            chk({7'h0, IRQ}, 8'h01);
            rd(8'hC8, v);
            chk(v, 8'hC4);
            wr(8'hC8, 8'h00);
            chk({7'h0, IRQ}, 8'h00);
            rd(8'hCD, hi);
            chk(hi, 8'h12);
            rd(8'hCC, v);
            repeat (10) @(negedge CLK);
            rd(8'hCC, lo);
            chk(lo, v);
            $display("test reload done");
        end
    endtask
    // split mode: free low byte, gated high byte, own reloads, low interrupt
    task t_split;
        begin
            CLOCK_CONTROL = 8'h30;
            wr(8'hCB, 8'hF8);
            wr(8'hCA, 8'hF0);
            wr(8'hCD, 8'hFE);
            wr(8'hCC, 8'hFC);
            wr(8'hC8, 8'h28);
            repeat (8) @(negedge CLK);
            chk({7'h0, IRQ}, 8'h01);
            rd(8'hC8, v);
            chk(v, 8'h68);
            rd(8'hCD, hi);
            chk(hi, 8'hFE);
            rd(8'hCC, lo);
            chk({7'h0, lo >= 8'hF0}, 8'h01);
            wr(8'hC8, 8'h2C);
            repeat (20) @(negedge CLK);
            rd(8'hC8, v);
            chk(v, 8'hEC);
            rd(8'hCD, hi);
            chk({7'h0, hi >= 8'hF8}, 8'h01);
            TIMER_IRQ_ENABLE = 1'b0;
            repeat (2) @(negedge CLK);
            chk({7'h0, IRQ}, 8'h00);
            TIMER_IRQ_ENABLE = 1'b1;
            wr(8'hC8, 8'h00);
            $display("test split done");
        end
    endtask
    // count clock choices; spans of 242 system clocks
    task t_clocks;
        begin
            run(8'h10, 8'h04, 8'hF0, 8'hF4);
            run(8'h00, 8'h04, 8'h13, 8'h15);
            run(8'h20, 8'h04, 8'h13, 8'h15);
            run(8'h10, 8'h08, 8'hF0, 8'hF4);
            run(8'h00, 8'h05, 8'h04, 8'h07);
            run(8'h00, 8'h07, 8'h01, 8'h03);
            $display("test clocks done");
        end
    endtask
    // capture from each source: flag set, reload replaced by a past count
    task t_capture;
        begin
            CLOCK_CONTROL = 8'h10;
            for (i = 0; i < 2; i = i + 1)
            begin
                wr(8'hCD, 8'h00);
                wr(8'hCC, 8'h00);
                wr(8'hC8, {6'h05, i[0], 1'b0});
                repeat (200) @(negedge CLK);
                rd(8'hC8, v);
                chk(v, {6'h25, i[0], 1'b0});
                wr(8'hC8, 8'h00);
                rd(8'hCB, hi);
                rd(8'hCA, lo);
                rd(8'hCC, v);
                chk({7'h0, hi == 8'h00 && lo != 8'h00 && lo < v}, 8'h01);
            end
            $display("test capture done");
        end
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(negedge CLK);
        RESETN = 1'b1;
        t_reset;
        t_reload;
        t_split;
        t_clocks;
        t_capture;
        print_verdict;
    end
    // watchdog: the tests need about 2100 cycles
    initial
    begin
        #80000;
        err_total = err_total + 1;
        print_verdict;
    end
endmodule // testbench
